// file: include/oup_defs.svh
// How it works
// - Address: low nibble register, channel, global bit.
// - Drive data bus only during reads.
// - Mode high: separate strobes, chip select enables.
// - Mode high: read starts on read strobe fall.
// - Mode high: write loads data on write strobe rise.
// - Mode low: read strobe held high.
// - Mode low: write pin is direction line.
// - Mode low: chip select is the strobe.
// - One open-drain active-low shared interrupt output.
`ifndef OUP_DEFS_SVH
`define OUP_DEFS_SVH
`define OUP_REG_LSB      0
`define OUP_REG_MSB      3
`define OUP_CH_LSB       4
`define OUP_CH_MSB       6
`define OUP_GLOBAL_BIT   7
`define OUP_NUM_CH       8
`define OUP_REGS_PER_CH  16
`define OUP_NUM_GLOBAL   16
`define OUP_RESET_VALUE  8'h00
`define OUP_STROBE_CYC   4
`define OUP_SETUP_CYC    4
`endif

// file: include/oup_pkg.sv
package oup_pkg;
	typedef enum logic [1:0] {
		OUP_ACC_NONE,
		OUP_ACC_READ,
		OUP_ACC_WRITE
	} oup_acc_t;
	typedef enum {
		OUP_H_IDLE,
		OUP_H_SETUP,
		OUP_H_STROBE,
		OUP_H_HOLD
	} oup_host_state_t;
endpackage : oup_pkg

// file: include/oup_bus_if.sv
`timescale 1ns/1ns
interface oup_bus_if;
	logic [7:0] addr_in;
	logic [7:0] data_host_out;
	logic       data_host_oe;
	logic [7:0] data_dev_out;
	logic       data_dev_oe;
	logic       bus_mode;
	logic       read_strobe_n;
	logic       write_strobe_n;
	logic       chip_sel_n;
	logic       irq_dev_oe;
	wire  [7:0] data_io;
	wire        irq_n;
	assign data_io = data_dev_oe ? data_dev_out : (data_host_oe ? data_host_out : 8'hFF);
	assign irq_n   = irq_dev_oe ? 1'b0 : 1'b1;
	modport device (
		input  addr_in, bus_mode, read_strobe_n, write_strobe_n, chip_sel_n, data_io,
		output data_dev_out, data_dev_oe, irq_dev_oe
	);
	modport host (
		input  data_io, irq_n,
		output addr_in, data_host_out, data_host_oe, bus_mode, read_strobe_n,
		output write_strobe_n, chip_sel_n
	);
endinterface : oup_bus_if

// file: src/oup_device.sv
`timescale 1ns/1ns
`include "oup_defs.svh"
module oup_device
	import oup_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	oup_bus_if.device       bus,
	input  wire logic [7:0] irq_src,
	output logic      [3:0] reg_sel,
	output logic      [2:0] ch_sel,
	output logic            global_sel,
	output logic      [7:0] wr_data,
	output logic            wr_pulse
);
	////////////////////////////////////////////////////////////////////////
	// Register storage. Reset leaves it as it was, so a location holds no
	// defined value until the host has written it once.
	logic [7:0] channel_regs [0:`OUP_NUM_CH*`OUP_REGS_PER_CH-1];
	logic [7:0] global_regs  [0:`OUP_NUM_GLOBAL-1];

	// Synchroniser stages: the first flop of each pair ends in _s1, the second in _s.
	logic       rd_s1, rd_s;
	logic       wr_s1, wr_s;
	logic       cs_s1, cs_s;
	logic [7:0] addr_s1, addr_s;
	logic [7:0] dat_s1, dat_s;
	logic       mode_s1, mode_s;

	// Decoded strobes, their copies one clock older, and the edges between them.
	logic       rd_act, wr_act;
	logic       rd_prev, wr_prev;
	logic       rd_start, rd_busy, wr_done;

	// Next values of the registered bus drivers.
	logic [7:0] next_data_dev_out;
	logic       next_data_dev_oe;
	logic       next_irq_dev_oe;

	////////////////////////////////////////////////////////////////////////
	// Flat index of a channel register: the channel sits above the register.
	function automatic logic [6:0] chan_index(
		input logic [2:0] ch,
		input logic [3:0] rg
	);
		return {ch, rg};
	endfunction : chan_index

	// Separate mode: chip select gates the read strobe. Single mode: chip select is
	// the strobe and a high write pin asks for a read; the read pin is strapped high
	// there and ignored, so a badly strapped board cannot start a read.
	function automatic logic read_request(
		input logic sep,
		input logic rd_n,
		input logic wr_n,
		input logic cs_n
	);
		if (sep)
			return !rd_n && !cs_n;
		else
			return !cs_n && wr_n;
	endfunction : read_request

	// Both conventions write while select and the write pin are low together.
	function automatic logic write_request(
		input logic wr_n,
		input logic cs_n
	);
		return !wr_n && !cs_n;
	endfunction : write_request

	////////////////////////////////////////////////////////////////////////
	// Host pins are asynchronous to clk, so each passes two flops before use.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_s1 <= 1'b1;
			rd_s  <= 1'b1;
			wr_s1 <= 1'b1;
			wr_s  <= 1'b1;
			cs_s1 <= 1'b1;
			cs_s  <= 1'b1;
		end else begin
			rd_s1 <= bus.read_strobe_n;
			rd_s  <= rd_s1;
			wr_s1 <= bus.write_strobe_n;
			wr_s  <= wr_s1;
			cs_s1 <= bus.chip_sel_n;
			cs_s  <= cs_s1;
		end
	end

	// Address and data use the same two stages as the strobes, so they are never
	// seen later than the strobe edge that acts on them.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			addr_s1 <= 8'h00;
			addr_s  <= 8'h00;
		end else begin
			addr_s1 <= bus.addr_in;
			addr_s  <= addr_s1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dat_s1 <= 8'h00;
			dat_s  <= 8'h00;
		end else begin
			dat_s1 <= bus.data_io;
			dat_s  <= dat_s1;
		end
	end

	// The mode pin is a board strap; a change is honoured two clocks later.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_s1 <= 1'b1;
			mode_s  <= 1'b1;
		end else begin
			mode_s1 <= bus.bus_mode;
			mode_s  <= mode_s1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	assign rd_act = read_request(mode_s, rd_s, wr_s, cs_s);
	assign wr_act = write_request(wr_s, cs_s);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_prev <= 1'b0;
			wr_prev <= 1'b0;
		end else begin
			rd_prev <= rd_act;
			wr_prev <= wr_act;
		end
	end

	// Writes commit on the end of the strobe, so data the host sets late still lands.
	assign rd_start = rd_act && !rd_prev;
	assign rd_busy  = rd_act && rd_prev;
	assign wr_done  = wr_prev && !wr_act;

	assign reg_sel    = addr_s[`OUP_REG_MSB:`OUP_REG_LSB];
	assign ch_sel     = addr_s[`OUP_CH_MSB:`OUP_CH_LSB];
	assign global_sel = addr_s[`OUP_GLOBAL_BIT];

	////////////////////////////////////////////////////////////////////////
	// One pulse per strobe: wr_done is true for a single clock only.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			wr_pulse <= 1'b0;
		else
			wr_pulse <= wr_done;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			wr_data <= `OUP_RESET_VALUE;
		else if (wr_done)
			wr_data <= dat_s;
	end

	always_ff @(posedge clk) begin
		if (wr_done) begin
			if (global_sel)
				global_regs[reg_sel] <= dat_s;
			else
				channel_regs[chan_index(ch_sel, reg_sel)] <= dat_s;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read data is fetched once at the strobe fall and held for the whole strobe.
	always_comb begin
		next_data_dev_out = bus.data_dev_out;
		if (rd_start) begin
			if (global_sel)
				next_data_dev_out = global_regs[reg_sel];
			else
				next_data_dev_out = channel_regs[chan_index(ch_sel, reg_sel)];
		end
	end

	assign next_data_dev_oe = rd_busy;

	// The data bus is driven one clock after the byte is loaded, so the pins
	// never show a stale byte from an earlier read.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			bus.data_dev_out <= `OUP_RESET_VALUE;
		else
			bus.data_dev_out <= next_data_dev_out;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			bus.data_dev_oe <= 1'b0;
		else
			bus.data_dev_oe <= next_data_dev_oe;
	end

	////////////////////////////////////////////////////////////////////////
	// The line is only ever pulled low; the board pull-up gives the high level,
	// so other devices can share it.
	assign next_irq_dev_oe = |irq_src;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			bus.irq_dev_oe <= 1'b0;
		else
			bus.irq_dev_oe <= next_irq_dev_oe;
	end
endmodule : oup_device

// file: src/oup_host.sv
`timescale 1ns/1ns
`include "oup_defs.svh"
module oup_host
	import oup_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	oup_bus_if.host         bus,
	input  wire logic       sep_mode,
	input  wire logic       req_valid,
	input  wire logic       req_write,
	input  wire logic [7:0] req_addr,
	input  wire logic [7:0] req_wdata,
	output logic            req_ready,
	output logic            rsp_valid,
	output logic      [7:0] rsp_rdata,
	output logic            irq_pending
);
	oup_host_state_t state;
	logic [3:0]      cnt;
	logic            is_wr;
	logic [1:0]      irq_s;

	assign req_ready = (state == OUP_H_IDLE);
	assign bus.bus_mode = sep_mode;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state              <= OUP_H_IDLE;
			cnt                <= 4'h0;
			is_wr              <= 1'b0;
			bus.addr_in        <= 8'h00;
			bus.data_host_out  <= 8'h00;
			bus.data_host_oe   <= 1'b0;
			bus.read_strobe_n  <= 1'b1;
			bus.write_strobe_n <= 1'b1;
			bus.chip_sel_n     <= 1'b1;
			rsp_valid          <= 1'b0;
			rsp_rdata          <= 8'h00;
		end else begin
			rsp_valid <= 1'b0;
			case (state)
				OUP_H_IDLE: begin
					if (req_valid) begin
						is_wr             <= req_write;
						bus.addr_in       <= req_addr;
						bus.data_host_out <= req_wdata;
						bus.data_host_oe  <= req_write;
						// Single mode: direction set before the strobe.
						bus.write_strobe_n <= sep_mode ? 1'b1 : !req_write;
						bus.read_strobe_n  <= 1'b1;
						bus.chip_sel_n     <= !sep_mode;
						cnt   <= 4'(`OUP_SETUP_CYC);
						state <= OUP_H_SETUP;
					end
				end
				OUP_H_SETUP: begin
					if (cnt == 4'h0) begin
						if (sep_mode) begin
							bus.read_strobe_n  <= is_wr;
							bus.write_strobe_n <= !is_wr;
						end else begin
							bus.chip_sel_n <= 1'b0;
						end
						cnt   <= 4'(`OUP_STROBE_CYC * 2);
						state <= OUP_H_STROBE;
					end else
						cnt <= cnt - 4'h1;
				end
				OUP_H_STROBE: begin
					if (cnt == 4'h0) begin
						rsp_rdata <= bus.data_io;
						rsp_valid <= !is_wr;
						bus.read_strobe_n <= 1'b1;
						if (sep_mode)
							bus.write_strobe_n <= 1'b1;
						else
							bus.chip_sel_n <= 1'b1;
						cnt   <= 4'(`OUP_SETUP_CYC);
						state <= OUP_H_HOLD;
					end else
						cnt <= cnt - 4'h1;
				end
				OUP_H_HOLD: begin
					if (cnt == 4'h0) begin
						bus.chip_sel_n     <= 1'b1;
						bus.write_strobe_n <= 1'b1;
						bus.data_host_oe   <= 1'b0;
						state              <= OUP_H_IDLE;
					end else
						cnt <= cnt - 4'h1;
				end
				default: state <= OUP_H_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_s       <= 2'h0;
			irq_pending <= 1'b0;
		end else begin
			irq_s       <= {irq_s[0], !bus.irq_n};
			irq_pending <= irq_s[1];
		end
	end
endmodule : oup_host

// file: tb/oup_bus_chk.sv
`timescale 1ns/1ns
module oup_bus_chk (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic bus_mode,
	input wire logic read_strobe_n,
	input wire logic write_strobe_n,
	input wire logic chip_sel_n,
	input wire logic data_dev_oe,
	input wire logic data_host_oe
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////////////////////////////
	one_driver_a: assert property (!(data_dev_oe && data_host_oe))
		else $error("both ends drive data");
	sep_read_a: assert property ($fell(read_strobe_n) && bus_mode && !chip_sel_n
		|-> ##[1:6] data_dev_oe) else $error("no read data");
	sep_release_a: assert property ($rose(read_strobe_n) && bus_mode
		|-> ##[1:6] !data_dev_oe) else $error("data not released");
	sep_write_a: assert property ((bus_mode && !write_strobe_n) [*4]
		|-> !data_dev_oe) else $error("driven in write");
	single_read_a: assert property ($fell(chip_sel_n) && !bus_mode && write_strobe_n
		|-> ##[1:6] data_dev_oe) else $error("no read data");
	single_write_a: assert property ((!bus_mode && !chip_sel_n && !write_strobe_n) [*4]
		|-> !data_dev_oe) else $error("driven in write");
	single_release_a: assert property ($rose(chip_sel_n) && !bus_mode
		|-> ##[1:6] !data_dev_oe) else $error("data not released");
	cs_held_a: assert property (bus_mode && !(read_strobe_n && write_strobe_n)
		|-> !chip_sel_n) else $error("strobe without select");
	rd_parked_a: assert property (!bus_mode |-> read_strobe_n)
		else $error("read strobe moved");
	cover property ($fell(read_strobe_n) && bus_mode);
	cover property ($fell(chip_sel_n) && !bus_mode && !write_strobe_n);
	cover property ($rose(data_dev_oe) && !bus_mode);
endmodule : oup_bus_chk

// file: tb/octal_uart_host_bus_port_test.sv
`timescale 1ns/1ns
module octal_uart_host_bus_port_test;
	logic clk, rst_n, sep_mode, req_valid, req_write, req_ready, rsp_valid;
	logic irq_pending, global_sel, wr_pulse;
	logic [7:0] req_addr, req_wdata, irq_src, rsp_rdata, wr_data, rd_val, seen, seen_d;
	logic [3:0] reg_sel;
	logic [2:0] ch_sel;
	int err_count, checks_done, pulses;
	logic [7:0] addrs [5] = '{8'h00, 8'h1F, 8'h75, 8'h80, 8'h8F};
	oup_bus_if bus ();
	oup_device u_oup_device (.clk(clk), .rst_n(rst_n), .bus(bus), .irq_src(irq_src),
		.reg_sel(reg_sel), .ch_sel(ch_sel), .global_sel(global_sel), .wr_data(wr_data),
		.wr_pulse(wr_pulse));
	oup_host u_oup_host (.clk(clk), .rst_n(rst_n), .bus(bus), .sep_mode(sep_mode),
		.req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
		.req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
		.rsp_rdata(rsp_rdata), .irq_pending(irq_pending));
	oup_bus_chk u_oup_bus_chk (.clk(clk), .rst_n(rst_n), .bus_mode(bus.bus_mode),
		.read_strobe_n(bus.read_strobe_n), .write_strobe_n(bus.write_strobe_n),
		.chip_sel_n(bus.chip_sel_n), .data_dev_oe(bus.data_dev_oe),
		.data_host_oe(bus.data_host_oe));
	////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// A second pulse for one strobe would show up here as a count above one.
	always @(posedge clk) begin
		if (wr_pulse === 1'b1) begin
			pulses++;
			seen = {global_sel, ch_sel, reg_sel};
			seen_d = wr_data;
		end
	end
	function automatic logic [7:0] dval(input logic [7:0] a, input logic m);
		return a ^ (m ? 8'h5A : 8'hC3);
	endfunction : dval
	task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task conclude;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : conclude
	task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		rd_val = 8'hXX;
		req_valid = 1'b1;
		req_write = w;
		req_addr = a;
		req_wdata = d;
		@(posedge clk);
		#1;
		req_valid = 1'b0;
		for (n = 0; n < 40 && req_ready !== 1'b1; n++) begin
			@(posedge clk);
			#1;
			if (rsp_valid === 1'b1)
				rd_val = rsp_rdata;
		end
		if (n == 40) begin
			chk("timeout", 8'h00, 8'h01);
			conclude();
		end
	endtask : acc
	task irq(input logic [7:0] src, input logic lvl);
		irq_src = src;
		for (int k = 0; k < 10 && irq_pending !== lvl; k++)
			@(posedge clk);
		#1;
		chk("irq_pending", {7'h00, lvl}, {7'h00, irq_pending});
		chk("irq_n", {7'h00, !lvl}, {7'h00, bus.irq_n});
	endtask : irq
	////////////////////////////////////////////////////////////////
	initial begin
		{rst_n, req_valid, req_write, req_addr, req_wdata, irq_src} = '0;
		sep_mode = 1'b1;
		repeat (8) @(posedge clk);
		#1;
		rst_n = 1'b1;
		// Separate strobes first: leaving single mode could park the direction line low.
		for (int m = 1; m >= 0; m--) begin
			sep_mode = m[0];
			foreach (addrs[i]) begin
				pulses = 0;
				acc(1'b1, addrs[i], dval(addrs[i], m[0]));
				chk("wr_pulse", 8'h01, pulses[7:0]);
				chk("select", addrs[i], seen);
				chk("wr_data", dval(addrs[i], m[0]), seen_d);
			end
			foreach (addrs[i]) begin
				acc(1'b0, addrs[i], 8'h00);
				chk("rd_data", dval(addrs[i], m[0]), rd_val);
				chk("idle data", 8'hFF, bus.data_io);
			end
		end
		irq(8'h04, 1'b1);
		irq(8'h00, 1'b0);
		conclude();
	end
endmodule : octal_uart_host_bus_port_test
